// file: pkg/tcr_pkg.sv
// Package: register addresses, field layout and sizes for the context registers
package tcr_pkg;
    localparam int          NUM_CTX        = 4;
    localparam int          CTX_W          = 2;
    localparam int          XLEN           = 32;
    localparam logic [4:0]  COP_REG_NUM    = 5'h02;
    localparam logic [2:0]  SEL_BINDING    = 3'h2;
    localparam logic [2:0]  SEL_RESUME     = 3'h3;
    localparam int          IDX_HI         = 28;
    localparam int          IDX_LO         = 21;
    localparam int          ZERO_HI        = 20;
    localparam int          ZERO_LO        = 18;
    localparam int          FAULT_BIT      = 17;
    localparam int          VCPU_HI        = 3;
    localparam int          VCPU_LO        = 0;
    localparam logic        FAULT_RST      = 1'b0;
    localparam logic [3:0]  VCPU_RST_CTX0  = 4'h0;
    localparam logic [XLEN-1:0] RESUME_RST = 32'h0000_0000;
    localparam int          MODE_BIT       = 0;
endpackage : tcr_pkg

// file: pkg/tcr_ctx_if.sv
// Interface: per-context signals between the bank and one context slice
`timescale 1ns/1ps
interface tcr_ctx_if;
    import tcr_pkg::*;
    logic                wr_bind;
    logic                wr_resume;
    logic [XLEN-1:0]     wdata;
    logic                cfg_en;
    logic                fault_set;
    logic                save;
    logic [XLEN-1:0]     save_pc;
    logic                save_mode;
    logic [XLEN-1:0]     bind_val;
    logic [XLEN-1:0]     resume_val;
    logic                sw_resume_wr;
    modport bank (output wr_bind, wr_resume, wdata, cfg_en, fault_set, save,
                  save_pc, save_mode, input bind_val, resume_val,
                  sw_resume_wr);
    modport ctx  (input wr_bind, wr_resume, wdata, cfg_en, fault_set, save,
                  save_pc, save_mode, output bind_val, resume_val,
                  sw_resume_wr);
endinterface : tcr_ctx_if

// file: design/tcr_ctx.sv
// Module: binding and resume registers of one thread context
`timescale 1ns/1ps
module tcr_ctx
    import tcr_pkg::*;
#(
    parameter logic [7:0] CTX_INDEX = 8'h00,
    parameter logic [3:0] VCPU_PRESET = 4'h0
) (
    input  wire logic clk,
    input  wire logic reset,
    tcr_ctx_if.ctx    c
);
    logic        fault;
    logic [3:0]  vcpu;
    logic [XLEN-1:0] resume;
    logic        sw_wr;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault <= FAULT_RST;
            vcpu  <= (CTX_INDEX == 8'h00) ? VCPU_RST_CTX0 : VCPU_PRESET;
        end else begin
            // Hardware set wins over a software clear in the same cycle
            if (c.fault_set)
                fault <= 1'b1;
            else if (c.wr_bind)
                fault <= c.wdata[FAULT_BIT];
            if (c.wr_bind && c.cfg_en)
                vcpu <= c.wdata[VCPU_HI:VCPU_LO];
        end
    end

    // Restart address has no defined reset; zero keeps simulation clean
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            resume <= RESUME_RST;
            sw_wr  <= 1'b0;
        end else begin
            sw_wr <= c.wr_resume;
            if (c.wr_resume)
                resume <= c.wdata;
            else if (c.save)
                resume <= {c.save_pc[XLEN-1:1], c.save_mode};
        end
    end

    assign c.bind_val = {3'h0, CTX_INDEX, 3'h0, fault, 13'h0000, vcpu};
    assign c.resume_val   = resume;
    assign c.sw_resume_wr = sw_wr;
endmodule : tcr_ctx

// file: design/tcr_bank.sv
// Module: per-context binding and resume register bank on coprocessor moves
`timescale 1ns/1ps
// Function
// - Binding at register 2 select 2, resume at select 3, per context.
// - Binding bits 28:21 read the context's own index.
// - Binding bits 20:18 always read zero.
// - Bit 17 bus-fault flag set by attributed bus error, software RW, reset 0.
// - One merged bus error may set several contexts' fault flags.
// - Unattributed bus errors may leave every fault flag untouched.
// - Bits 3:0 vcpu binding writable only while config enable set.
// - Bits 31:29 and 16:4 read zero; software writes zero.
// - Resume register is general-register wide, per context, undefined reset.
// - When halted, reads give restart address and writes change it.
// - Restart address passes a branch only after its delay slot retires.
// - Software resume write clears that context's delay-slot flag.
// - Resume write between load-linked and store-conditional fails the latter.
// - Hardware save packs pc bits 31..1 with mode in bit 0.
// - Restart takes pc bits 31..1 with zero lsb, mode from bit 0.
// - Resume reads return the last value written or saved, bit 0 unchanged.
module tcr_bank
    import tcr_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                cop_wr,
    input  wire logic                cop_rd,
    input  wire logic [4:0]          cop_reg,
    input  wire logic [2:0]          cop_sel,
    input  wire logic [CTX_W-1:0]    cop_ctx,
    input  wire logic [XLEN-1:0]     cop_wdata,
    output logic [XLEN-1:0]          cop_rdata,
    output logic                     cop_rvalid,
    input  wire logic                binding_config_enable,
    input  wire logic [NUM_CTX-1:0]  data_bus_error,
    input  wire logic [NUM_CTX-1:0]  ctx_halted,
    input  wire logic [NUM_CTX-1:0]  retire_save,
    input  wire logic [XLEN-1:0]     retire_pc,
    input  wire logic                retire_in_delay_slot,
    input  wire logic                retire_mode,
    input  wire logic [CTX_W-1:0]    restart_ctx,
    input  wire logic [NUM_CTX-1:0]  load_linked_op,
    input  wire logic [NUM_CTX-1:0]  store_conditional_op,
    output logic [XLEN-1:0]          restart_pc,
    output logic                     restart_mode,
    output logic [NUM_CTX-1:0]       delay_slot_clear,
    output logic [NUM_CTX-1:0]       link_broken,
    output logic [NUM_CTX-1:0]       context_bus_fault
);
    logic [NUM_CTX-1:0]    sel_ctx;
    logic [XLEN-1:0]       bind_v   [NUM_CTX];
    logic [XLEN-1:0]       resume_v [NUM_CTX];
    logic [NUM_CTX-1:0]    sw_wr;
    logic [NUM_CTX-1:0]    link_valid;
    wire hit_bind   = (cop_reg == COP_REG_NUM) && (cop_sel == SEL_BINDING);
    wire hit_resume = (cop_reg == COP_REG_NUM) && (cop_sel == SEL_RESUME);
    wire [XLEN-1:0] rd_mux = hit_bind ? bind_v[cop_ctx]
                           : hit_resume ? resume_v[cop_ctx] : '0;

    genvar g;
    generate
        for (g = 0; g < NUM_CTX; g++) begin : g_ctx
            tcr_ctx_if cif ();
            assign sel_ctx[g]      = (cop_ctx == CTX_W'(g));
            assign cif.wr_bind     = cop_wr && hit_bind && sel_ctx[g];
            // Writes to a running context are undefined; only halted accepted
            assign cif.wr_resume   = cop_wr && hit_resume && sel_ctx[g]
                                     && ctx_halted[g];
            assign cif.wdata       = cop_wdata;
            assign cif.cfg_en      = binding_config_enable;
            assign cif.fault_set   = data_bus_error[g];
            // Save only once the delay slot has retired
            assign cif.save        = retire_save[g]
                                     && !retire_in_delay_slot;
            assign cif.save_pc     = retire_pc;
            assign cif.save_mode   = retire_mode;
            assign bind_v[g]       = cif.bind_val;
            assign resume_v[g]     = cif.resume_val;
            assign sw_wr[g]        = cif.sw_resume_wr;
            tcr_ctx #(
                .CTX_INDEX   (8'(g)),
                .VCPU_PRESET (4'(g))
            ) u_ctx (
                .clk   (clk),
                .reset (reset),
                .c     (cif)
            );
            always_ff @(posedge clk or posedge reset) begin
                if (reset)
                    link_valid[g] <= 1'b0;
                else if (load_linked_op[g])
                    link_valid[g] <= 1'b1;
                else if (sw_wr[g] || store_conditional_op[g])
                    link_valid[g] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cop_rdata         <= '0;
            cop_rvalid        <= 1'b0;
            restart_pc        <= '0;
            restart_mode      <= 1'b0;
            delay_slot_clear  <= '0;
            link_broken       <= '0;
            context_bus_fault <= '0;
        end else begin
            cop_rvalid        <= cop_rd;
            cop_rdata         <= cop_rd ? rd_mux : '0;
            restart_pc        <= {resume_v[restart_ctx][XLEN-1:1], 1'b0};
            restart_mode      <= resume_v[restart_ctx][MODE_BIT];
            delay_slot_clear  <= sw_wr;
            link_broken       <= ~link_valid;
            for (int i = 0; i < NUM_CTX; i++)
                context_bus_fault[i] <= bind_v[i][FAULT_BIT];
        end
    end
endmodule : tcr_bank

// file: tb/tcr_bank_asserts.sv
// Port checker for the context register bank
`timescale 1ns/1ps
module tcr_bank_asserts import tcr_pkg::*; (
    input logic               clk,
    input logic               reset,
    input logic               cop_wr,
    input logic               cop_rd,
    input logic [4:0]         cop_reg,
    input logic [2:0]         cop_sel,
    input logic [CTX_W-1:0]   cop_ctx,
    input logic [XLEN-1:0]    cop_rdata,
    input logic               cop_rvalid,
    input logic [NUM_CTX-1:0] ctx_halted,
    input logic [NUM_CTX-1:0] data_bus_error,
    input logic [XLEN-1:0]    restart_pc,
    input logic [NUM_CTX-1:0] delay_slot_clear,
    input logic [NUM_CTX-1:0] link_broken,
    input logic [NUM_CTX-1:0] context_bus_fault
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire bnd = cop_rd && cop_reg == COP_REG_NUM && cop_sel == SEL_BINDING;
    wire rsw = cop_wr && cop_reg == COP_REG_NUM && cop_sel == SEL_RESUME
               && ctx_halted[cop_ctx];
    a_rd_answer: assert property (cop_rd |=> cop_rvalid)
        else $error("read not answered");
    a_bind_index: assert property (bnd |=> cop_rdata[28:21] == $past(cop_ctx))
        else $error("wrong own index");
    a_bind_zeros: assert property (bnd |=> cop_rdata[31:29] == 3'h0
        && cop_rdata[20:18] == 3'h0 && cop_rdata[16:4] == 13'h0)
        else $error("reserved bits not zero");
    // Flag sets one edge after the error, the mirror output one edge later
    a_fault_set: assert property (data_bus_error != 0 |-> ##2
        (context_bus_fault & $past(data_bus_error, 2))
        == $past(data_bus_error, 2))
        else $error("fault flag not set");
    a_restart_lsb: assert property (restart_pc[0] == 1'b0)
        else $error("restart pc lsb set");
    a_slot_clear: assert property (rsw |-> ##2 delay_slot_clear[$past(cop_ctx, 2)])
        else $error("slot flag not cleared");
    a_slot_cause: assert property (delay_slot_clear != 0 |->
        $past(rsw, 2))
        else $error("slot clear without write");
    // Write flag, link state and output each add one register stage
    a_link_break: assert property (rsw |-> ##3
        link_broken[$past(cop_ctx, 3)])
        else $error("link kept after write");
    c_fault: cover property (data_bus_error != 0);
    c_resume: cover property (rsw);
    c_bind: cover property (bnd);
endmodule : tcr_bank_asserts
bind tcr_bank tcr_bank_asserts u_chk (.*);

// file: tb/tcr_pipe_model.sv
// Pipeline model: saves restart state, reports bus errors and links
`timescale 1ns/1ps
module tcr_pipe_model import tcr_pkg::*; (
    input logic               clk,
    output logic [NUM_CTX-1:0] data_bus_error,
    output logic [NUM_CTX-1:0] ctx_halted,
    output logic [NUM_CTX-1:0] retire_save,
    output logic [XLEN-1:0]   retire_pc,
    output logic              retire_in_delay_slot,
    output logic              retire_mode,
    output logic [CTX_W-1:0]  restart_ctx,
    output logic [NUM_CTX-1:0] load_linked_op,
    output logic [NUM_CTX-1:0] store_conditional_op
);
    initial begin
        {data_bus_error, retire_save, load_linked_op} = '0;
        {retire_pc, retire_in_delay_slot, retire_mode, restart_ctx} = '0;
        store_conditional_op = '0;
        // Context 0 runs; software rewrites only halted ones
        ctx_halted = 4'he;
    end
    task step(input [3:0] e, s, l, input [31:0] pc, input m, d, input [1:0] r);
        @(posedge clk);
        {data_bus_error, retire_save, load_linked_op} <= {e, s, l};
        {retire_pc, retire_mode, retire_in_delay_slot} <= {pc, m, d};
        restart_ctx <= r;
        @(posedge clk);
        {data_bus_error, retire_save, load_linked_op} <= '0;
        // Stale pc is scrambled so it can never be mistaken for data
        retire_pc <= ~pc;
    endtask : step
    task sc(input [3:0] s);
        @(posedge clk);
        store_conditional_op <= s;
        @(posedge clk);
        store_conditional_op <= '0;
    endtask : sc
endmodule : tcr_pipe_model

// file: tb/tb_tcr_bank.sv
// Testbench for the context register bank
`timescale 1ns/1ps
module tb_tcr_bank import tcr_pkg::*;;
    logic clk, reset, cop_wr, cop_rd, binding_config_enable, cop_rvalid;
    logic retire_in_delay_slot, retire_mode, restart_mode;
    logic [4:0] cop_reg;
    logic [2:0] cop_sel;
    logic [CTX_W-1:0] cop_ctx, restart_ctx;
    logic [XLEN-1:0] cop_wdata, cop_rdata, retire_pc, restart_pc, v;
    logic [NUM_CTX-1:0] data_bus_error, ctx_halted, retire_save, link_broken;
    logic [NUM_CTX-1:0] load_linked_op, store_conditional_op;
    logic [NUM_CTX-1:0] delay_slot_clear, context_bus_fault;
    int n_mismatch, check_count, cyc;
    tcr_bank DUT (.*);
    tcr_pipe_model PM (.*);
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task finish_test;
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task wr(input [1:0] c, input [2:0] s, input [31:0] d);
        @(posedge clk);
        {cop_wr, cop_ctx, cop_sel, cop_wdata} <= {1'b1, c, s, d};
        @(posedge clk);
        cop_wr <= 0;
    endtask : wr
    task rd(input [4:0] r, input [1:0] c, input [2:0] s);
        @(posedge clk);
        {cop_rd, cop_reg, cop_ctx, cop_sel} <= {1'b1, r, c, s};
        @(posedge clk);
        {cop_rd, cop_reg} <= {1'b0, COP_REG_NUM};
        @(negedge clk);
        v = cop_rdata;
        chk("read valid", cop_rvalid, 1'b1);
    endtask : rd
    task t_bind;
        for (int g = 0; g < NUM_CTX; g++) begin
            rd(COP_REG_NUM, 2'(g), SEL_BINDING);
            chk("binding", v, {3'h0, 8'(g), 17'h0, 4'(g)});
        end
        wr(1, SEL_BINDING, 32'h5);
        rd(COP_REG_NUM, 1, SEL_BINDING);
        chk("vcpu locked", v[3:0], 4'h1);
        @(posedge clk) binding_config_enable <= 1;
        wr(2, SEL_BINDING, 32'ha);
        rd(COP_REG_NUM, 2, SEL_BINDING);
        chk("vcpu set", v, {3'h0, 8'h2, 17'h0, 4'ha});
        @(posedge clk) binding_config_enable <= 0;
        rd(5'h03, 0, SEL_BINDING);
        chk("unmapped", v, 32'h0);
    endtask : t_bind
    task t_fault;
        PM.step(4'h5, 0, 0, 0, 0, 0, 0);
        repeat (2) @(negedge clk);
        chk("fault", context_bus_fault, 4'h5);
        wr(2, SEL_BINDING, 32'h0);
        repeat (2) @(negedge clk);
        chk("fault clear", context_bus_fault, 4'h1);
    endtask : t_fault
    task t_resume;
        wr(0, SEL_RESUME, 32'h1234);
        rd(COP_REG_NUM, 0, SEL_RESUME);
        chk("running resume", v, 32'h0);
        PM.step(0, 0, 4'h2, 0, 0, 0, 0);
        repeat (2) @(negedge clk);
        chk("linked", link_broken[1], 1'b0);
        wr(1, SEL_RESUME, 32'h8000_1235);
        @(negedge clk);
        @(negedge clk);
        chk("slot clear", delay_slot_clear, 4'h2);
        rd(COP_REG_NUM, 1, SEL_RESUME);
        chk("resume", v, 32'h8000_1235);
        chk("link broken", link_broken[1], 1'b1);
        PM.step(0, 0, 4'h8, 0, 0, 0, 0);
        repeat (2) @(negedge clk);
        chk("linked 3", link_broken[3], 1'b0);
        PM.sc(4'h8);
        repeat (2) @(negedge clk);
        chk("sc ends link", link_broken[3], 1'b1);
    endtask : t_resume
    task t_save;
        PM.step(0, 4'h4, 0, 32'h4567, 1, 0, 2);
        rd(COP_REG_NUM, 2, SEL_RESUME);
        chk("saved", v, 32'h4567);
        chk("restart pc", restart_pc, 32'h4566);
        chk("restart mode", restart_mode, 1'b1);
        PM.step(0, 4'h4, 0, 32'h9998, 0, 1, 2);
        rd(COP_REG_NUM, 2, SEL_RESUME);
        chk("slot save", v, 32'h4567);
    endtask : t_save
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        {cop_wr, cop_rd, binding_config_enable, cop_ctx, cop_sel} = '0;
        {cop_reg, cop_wdata, reset} = {COP_REG_NUM, 32'h0, 1'b1};
        repeat (16) @(posedge clk);
        reset <= 0;
        t_bind();
        t_fault();
        t_resume();
        t_save();
        finish_test();
    end
endmodule : tb_tcr_bank
